// ---- verilog/comparator_control_regs.sv ----
// comparator control and status register bank on avalon-mm
`timescale 1ns/1ns
module comparator_control_regs
   import cmp_ctl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic comparator_raw_i,
   output logic external_ref_connect_o,
   output logic bandgap_connect_o,
   output logic [3:0] reference_level_field_o,
   output logic hysteresis_enable_o,
   output logic comparator_power_o,
   output logic shared_port_pin_o,
   output logic shared_port_pin_oe_o,
   output logic comparator_irq_o,
   output logic irq_o
);
   import cmp_ctl_pkg::*;

   logic [7:0] ref_q;
   logic [7:0] ctl_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic [2:0] sync_q;
   logic [EDGE_DELAY_CYC-1:0] dly_q;
   logic res_prev_q;
   logic ack_q;
   ref_src_t src_d;
   logic [7:0] idx;
   logic wr_lo;
   logic rd_go;
   logic raw_s;
   logic res_d;
   logic cmp_seen;

   assign idx = avs_address_i[9:2];
   // one wait cycle per access: ack pulse ends the request
   assign wr_lo = ce_i & avs_write_i & ack_q & avs_byteenable_i[0];
   assign rd_go = ce_i & avs_read_i & ack_q;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ack_q <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else if (ce_i) begin
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
         // registered copy of the inverted ack, so the pin comes from a flop
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
      end
   end

   // input synchroniser, change accepted when stages two and three agree
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sync_q <= 3'h0;
      end else if (ce_i) begin
         sync_q <= {sync_q[1:0], comparator_raw_i};
      end
   end
   assign raw_s = (sync_q[1] == sync_q[2]) ? sync_q[2] : res_prev_q;
   assign res_d = ctl_q[PWR_BIT] ? raw_s : 1'b1;

   // delay line models the edge latency; sync adds three more cycles
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         dly_q <= '1;
         res_prev_q <= 1'b1;
      end else if (ce_i) begin
         res_prev_q <= res_d;
         dly_q <= {dly_q[EDGE_DELAY_CYC-2:0], res_d};
      end
   end
   // rising when not inverted, falling when inverted
   assign cmp_seen = ctl_q[INV_BIT]
      ? (~dly_q[EDGE_DELAY_CYC-2] & dly_q[EDGE_DELAY_CYC-1])
      : (dly_q[EDGE_DELAY_CYC-2] & ~dly_q[EDGE_DELAY_CYC-1]);

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ref_q <= REF_SEL_RST;
      end else if (wr_lo && idx == REF_SEL_IDX) begin
         ref_q <= avs_writedata_i[7:0] & 8'hFC;
      end
   end

   // control bits: flag set wins over read clear
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ctl_q <= CMP_CTL_RST;
      end else if (ce_i) begin
         if (wr_lo && idx == CMP_CTL_IDX) begin
            ctl_q[HYST_BIT] <= avs_writedata_i[HYST_BIT];
            ctl_q[INV_BIT] <= avs_writedata_i[INV_BIT];
            ctl_q[IE_BIT] <= avs_writedata_i[IE_BIT];
            ctl_q[PIN_BIT] <= avs_writedata_i[PIN_BIT];
            ctl_q[PWR_BIT] <= avs_writedata_i[PWR_BIT];
         end
         ctl_q[6] <= 1'b0;
         ctl_q[RES_BIT] <= ctl_q[INV_BIT] ? ~res_d : res_d;
         if (cmp_seen) begin
            ctl_q[IF_BIT] <= 1'b1;
         end else if (rd_go && idx == CMP_CTL_IDX) begin
            ctl_q[IF_BIT] <= 1'b0;
         end
      end
   end

   // sticky event status: bit0 comparator edge, bit1 result change
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         stat_q <= 2'h0;
         mask_q <= 2'h0;
      end else if (ce_i) begin
         stat_q[0] <= cmp_seen | (stat_q[0] &
            ~(wr_lo && idx == IRQ_STAT_IDX && avs_writedata_i[0]));
         stat_q[1] <= (res_d != res_prev_q) | (stat_q[1] &
            ~(wr_lo && idx == IRQ_STAT_IDX && avs_writedata_i[1]));
         if (wr_lo && idx == IRQ_MASK_IDX) begin
            mask_q <= avs_writedata_i[1:0];
         end
      end
   end

   always_comb begin
      if (ref_q[EXT_BIT]) begin
         src_d = REF_EXTERNAL;
      end else if (ref_q[BGR_BIT]) begin
         src_d = REF_BANDGAP;
      end else begin
         src_d = REF_LEVEL;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         external_ref_connect_o <= 1'b0;
         bandgap_connect_o <= 1'b0;
         reference_level_field_o <= 4'h0;
         hysteresis_enable_o <= 1'b1;
         comparator_power_o <= 1'b0;
         shared_port_pin_o <= 1'b0;
         shared_port_pin_oe_o <= 1'b0;
         comparator_irq_o <= 1'b0;
         irq_o <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else if (ce_i) begin
         external_ref_connect_o <= (src_d == REF_EXTERNAL);
         bandgap_connect_o <= (src_d == REF_BANDGAP);
         reference_level_field_o <= ref_q[5:LVL_LSB];
         hysteresis_enable_o <= ctl_q[HYST_BIT];
         comparator_power_o <= ctl_q[PWR_BIT];
         shared_port_pin_o <= ctl_q[RES_BIT];
         shared_port_pin_oe_o <= ctl_q[PIN_BIT];
         comparator_irq_o <= ctl_q[IE_BIT] & ctl_q[IF_BIT];
         irq_o <= |(stat_q & mask_q);
         avs_readdata_o <= 32'h0;
         if (avs_read_i && !ack_q) begin
            unique case (idx)
               REF_SEL_IDX: avs_readdata_o <= {24'h0, ref_q};
               CMP_CTL_IDX: avs_readdata_o <= {24'h0, ctl_q};
               IRQ_STAT_IDX: avs_readdata_o <= {30'h0, stat_q};
               IRQ_MASK_IDX: avs_readdata_o <= {30'h0, mask_q};
               default: avs_readdata_o <= 32'h0;
            endcase
         end
      end
   end

   AST_IRQ_GATE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i |=> comparator_irq_o == $past(ctl_q[IE_BIT] & ctl_q[IF_BIT]))
      else $error("irq does not follow enable and flag");
   AST_FLAG_CLR: assert property (@(posedge mclk_i) disable iff (srst_i)
      rd_go && idx == CMP_CTL_IDX && !cmp_seen |=> !ctl_q[IF_BIT])
      else $error("read did not clear flag");
   AST_FLAG_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && cmp_seen |=> ctl_q[IF_BIT])
      else $error("edge did not set flag");
   AST_OFF_ONE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !ctl_q[PWR_BIT] |=> res_prev_q)
      else $error("powered-off result not one");
   AST_PRIO: assert property (@(posedge mclk_i) disable iff (srst_i)
      !(external_ref_connect_o && bandgap_connect_o))
      else $error("two reference sources at once");
   AST_RSVD: assert property (@(posedge mclk_i) disable iff (srst_i)
      ctl_q[6] == 1'b0 ##0 ref_q[1:0] == 2'h0)
      else $error("reserved bit set");
   AST_PIN: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !ctl_q[PIN_BIT] |=> !shared_port_pin_oe_o)
      else $error("pin driven while disabled");
   AST_INV: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i |=> ctl_q[RES_BIT] == ($past(ctl_q[INV_BIT]) ^ res_prev_q))
      else $error("result bit does not match inversion");

   AST_REF_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr_lo && idx == REF_SEL_IDX
      |=> ref_q == ($past(avs_writedata_i[7:0]) & 8'hFC))
      else $error("reference write did not land");

   AST_EXT_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> external_ref_connect_o == $past(ref_q[EXT_BIT]))
      else $error("external connect does not follow register");

   AST_BGR_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> bandgap_connect_o == $past(ref_q[BGR_BIT] & ~ref_q[EXT_BIT]))
      else $error("bandgap connect does not follow register");

   AST_LVL_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> reference_level_field_o == $past(ref_q[5:LVL_LSB]))
      else $error("level field does not follow register");

   AST_HYST_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> hysteresis_enable_o == $past(ctl_q[HYST_BIT]))
      else $error("hysteresis output does not follow register");

   AST_PWR_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> comparator_power_o == $past(ctl_q[PWR_BIT]))
      else $error("power output does not follow register");

   AST_PIN_VAL: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> shared_port_pin_o == $past(ctl_q[RES_BIT]))
      else $error("pin value does not follow result");

   AST_PIN_ON: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && ctl_q[PIN_BIT]
      |=> shared_port_pin_oe_o)
      else $error("pin not driven while enabled");

   AST_FLAG_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr_lo && idx == CMP_CTL_IDX && !cmp_seen
      |=> ctl_q[IF_BIT] == $past(ctl_q[IF_BIT]))
      else $error("write changed the flag");

   AST_FLAG_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !cmp_seen && !(rd_go && idx == CMP_CTL_IDX)
      |=> ctl_q[IF_BIT] == $past(ctl_q[IF_BIT]))
      else $error("flag moved without edge or read");

   AST_IE_WR: assert property (@(posedge mclk_i) disable iff (srst_i)
      wr_lo && idx == CMP_CTL_IDX
      |=> ctl_q[IE_BIT] == $past(avs_writedata_i[IE_BIT]))
      else $error("enable write did not land");

   AST_IRQ_LOW: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !ctl_q[IE_BIT]
      |=> !comparator_irq_o)
      else $error("irq raised while disabled");

   AST_RES_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !ctl_q[PWR_BIT]
      |=> ctl_q[RES_BIT] == ~$past(ctl_q[INV_BIT]))
      else $error("powered-off result bit wrong");

   AST_NO_EDGE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && dly_q[EDGE_DELAY_CYC-2] == dly_q[EDGE_DELAY_CYC-1]
      |-> !cmp_seen)
      else $error("edge seen on steady result");

   AST_RISE: assert property (@(posedge mclk_i) disable iff (srst_i)
      !ctl_q[INV_BIT] && dly_q[EDGE_DELAY_CYC-2] && !dly_q[EDGE_DELAY_CYC-1]
      |-> cmp_seen)
      else $error("rising edge missed");

   AST_FALL: assert property (@(posedge mclk_i) disable iff (srst_i)
      ctl_q[INV_BIT] && !dly_q[EDGE_DELAY_CYC-2] && dly_q[EDGE_DELAY_CYC-1]
      |-> cmp_seen)
      else $error("falling edge missed");

   AST_DLY_IN: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> dly_q[0] == $past(res_d))
      else $error("delay line did not take result");

   AST_RD_CTL: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && avs_read_i && !ack_q && idx == CMP_CTL_IDX
      |=> avs_readdata_o == {24'h0, $past(ctl_q)})
      else $error("control read data wrong");

   AST_RD_REF: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && avs_read_i && !ack_q && idx == REF_SEL_IDX
      |=> avs_readdata_o == {24'h0, $past(ref_q)})
      else $error("reference read data wrong");

   AST_WAIT_ONE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("request not answered after one wait");

   AST_WAIT_PULSE: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !avs_waitrequest_o
      |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   AST_WAIT_ACK: assert property (@(posedge mclk_i) disable iff (srst_i)
      avs_waitrequest_o == ~ack_q)
      else $error("waitrequest out of step with ack");

   AST_STAT_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && cmp_seen
      |=> stat_q[0])
      else $error("edge did not set status");

   AST_IRQ_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i
      |=> irq_o == $past(|(stat_q & mask_q)))
      else $error("irq does not follow status and mask");

   AST_FREEZE: assert property (@(posedge mclk_i) disable iff (srst_i)
      !ce_i
      |=> ctl_q == $past(ctl_q) && ref_q == $past(ref_q))
      else $error("state moved while clock enable low");

   AST_FREEZE_OUT: assert property (@(posedge mclk_i) disable iff (srst_i)
      !ce_i
      |=> irq_o == $past(irq_o) && avs_readdata_o == $past(avs_readdata_o))
      else $error("outputs moved while clock enable low");
endmodule

// ---- pkg/cmp_ctl_pkg.sv ----
// constants for the comparator control register bank
package cmp_ctl_pkg;
   // printed offsets are not multiples of four: they are indices, byte address = 4*index
   localparam logic [7:0] REF_SEL_IDX = 8'h2C;
   localparam logic [7:0] CMP_CTL_IDX = 8'h2D;
   localparam logic [7:0] IRQ_STAT_IDX = 8'h2E;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h2F;
   localparam logic [7:0] REF_SEL_RST = 8'h00;
   localparam logic [7:0] CMP_CTL_RST = 8'h80;
   localparam int EXT_BIT = 7;
   localparam int BGR_BIT = 6;
   localparam int LVL_LSB = 2;
   localparam int HYST_BIT = 7;
   localparam int INV_BIT = 5;
   localparam int IF_BIT = 4;
   localparam int IE_BIT = 3;
   localparam int RES_BIT = 2;
   localparam int PIN_BIT = 1;
   localparam int PWR_BIT = 0;
   localparam int CLK_MHZ = 25;
   localparam int EDGE_DELAY_NS = 250;
   // longest time rounds down
   localparam int EDGE_DELAY_CYC = (EDGE_DELAY_NS * CLK_MHZ) / 1000;
   typedef enum logic [1:0] {
      REF_LEVEL,
      REF_BANDGAP,
      REF_EXTERNAL
   } ref_src_t;
endpackage

// ---- testbench/comparator_model.sv ----
// behavioural comparator with reference ladder, far side of the bank
`timescale 1ns/1ns
module comparator_model #(
   parameter int EXT_MV = 2500
) (
   input wire logic power_i,
   input wire logic ext_i,
   input wire logic bgr_i,
   input wire logic [3:0] level_i,
   input wire logic [15:0] pos_mv_i,
   output logic raw_o
);
   int neg_mv;
   always_comb begin
      neg_mv = ext_i ? EXT_MV : bgr_i ? 1200 : 200 + 200 * level_i;
      raw_o = !power_i || (pos_mv_i > neg_mv);
   end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the comparator control bank
`timescale 1ns/1ns
module tb;
   import cmp_ctl_pkg::*;
   logic mclk_i = 0, srst_i = 1, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic [9:0] avs_address_i = '0;
   logic [31:0] avs_writedata_i = '0, avs_readdata_o;
   logic [15:0] pos_mv = 16'h0000;
   logic avs_waitrequest_o, comparator_raw_i, external_ref_connect_o, bandgap_connect_o;
   logic hysteresis_enable_o, comparator_power_o, shared_port_pin_o, shared_port_pin_oe_o;
   logic comparator_irq_o, irq_o;
   logic [3:0] reference_level_field_o;
   logic [7:0] rd, v, c;
   int n_fail = 0, cmp_count = 0;
   always #20 mclk_i = ~mclk_i;
   comparator_control_regs DUT (.mclk_i, .srst_i, .ce_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
      .avs_waitrequest_o, .comparator_raw_i, .external_ref_connect_o, .bandgap_connect_o,
      .reference_level_field_o, .hysteresis_enable_o, .comparator_power_o,
      .shared_port_pin_o, .shared_port_pin_oe_o, .comparator_irq_o, .irq_o);
   comparator_model PM (.power_i(comparator_power_o), .ext_i(external_ref_connect_o),
      .bgr_i(bandgap_connect_o), .level_i(reference_level_field_o), .pos_mv_i(pos_mv),
      .raw_o(comparator_raw_i));
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task stop_test;
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int t;
      @(posedge mclk_i);
      avs_address_i <= {idx, 2'b00};
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'h000000, wd};
      t = 0;
      do begin
         @(posedge mclk_i);
         t++;
      end while (avs_waitrequest_o !== 1'b0 && t < 50);
      if (t >= 50) n_fail++;
      rd = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   // analog input step, then settle past sync and edge delay
   task mv(input logic [15:0] m);
      @(posedge mclk_i);
      pos_mv <= m;
      repeat (14) @(posedge mclk_i);
   endtask
   initial begin
      v = 8'($urandom(32'h02E97B97));
      repeat (3) @(posedge mclk_i);
      srst_i <= 1'b0;
      bus(0, REF_SEL_IDX, 8'h00);
      chk("ref_rst", rd, REF_SEL_RST);
      bus(0, CMP_CTL_IDX, 8'h00);
      chk("ctl_rst", rd & 8'hEB, CMP_CTL_RST);
      chk("hyst", hysteresis_enable_o, 8'h01);
      bus(0, 8'h10, 8'h00);
      chk("unmapped", rd, 8'h00);
      for (int i = 0; i < 14; i++) begin
         v = i == 0 ? 8'hFC : i == 1 ? 8'h7C : 8'($urandom) & 8'hFC;
         bus(1, REF_SEL_IDX, v);
         bus(0, REF_SEL_IDX, 8'h00);
         chk("ref_rd", rd, v);
         chk("ext", external_ref_connect_o, v[7]);
         chk("bgr", bandgap_connect_o, v[6] & !v[7]);
         if (v[7:6] == 2'b00) chk("lvl", reference_level_field_o, v[5:2]);
      end
      bus(1, REF_SEL_IDX, 8'h20);
      for (int inv = 0; inv < 2; inv++) begin
         bus(1, CMP_CTL_IDX, inv ? 8'hA3 : 8'h83);
         mv(inv ? 16'h0BB8 : 16'h0000);
         c = inv ? 8'hBB : 8'h9B;
         bus(1, CMP_CTL_IDX, c);
         bus(0, CMP_CTL_IDX, 8'h00);
         chk("ctl_rd", rd & 8'hAB, c & 8'hAB);
         bus(0, CMP_CTL_IDX, 8'h00);
         chk("flag_wr", rd[4], 8'h00);
         chk("res0", rd[2], 8'h00);
         chk("pin_oe", shared_port_pin_oe_o, 8'h01);
         @(posedge mclk_i);
         pos_mv <= inv ? 16'h0000 : 16'h0BB8;
         repeat (4) @(posedge mclk_i);
         chk("early", comparator_irq_o, 8'h00);
         repeat (10) @(posedge mclk_i);
         chk("cirq", comparator_irq_o, 8'h01);
         chk("pin", shared_port_pin_o, 8'h01);
         bus(0, CMP_CTL_IDX, 8'h00);
         chk("flag", rd[4], 8'h01);
         chk("res1", rd[2], 8'h01);
         bus(0, CMP_CTL_IDX, 8'h00);
         chk("flag_rd", rd[4], 8'h00);
         @(negedge mclk_i);
         chk("cirq_clr", comparator_irq_o, 8'h00);
         mv(inv ? 16'h0BB8 : 16'h0000);
         bus(0, CMP_CTL_IDX, 8'h00);
         chk("wrong_edge", rd[4], 8'h00);
      end
      bus(1, IRQ_STAT_IDX, 8'h03);
      bus(1, IRQ_MASK_IDX, 8'h01);
      mv(16'h0000);
      chk("irq_set", irq_o, 8'h01);
      bus(1, IRQ_STAT_IDX, 8'h03);
      repeat (2) @(negedge mclk_i);
      chk("irq_clr", irq_o, 8'h00);
      bus(1, CMP_CTL_IDX, 8'h80);
      repeat (2) @(negedge mclk_i);
      chk("pwr_off", comparator_power_o, 8'h00);
      chk("pin_off", shared_port_pin_oe_o, 8'h00);
      stop_test;
   end
   // whole run needs about 260 cycles
   initial begin
      #400000;
      n_fail++;
      stop_test;
   end
endmodule
